// ==== rtl/data_frame_header_builder.sv ====
// data frame builder: common header, header check, body sub-headers
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - every frame holds one or two bodies; other counts are refused.
// - each body is one payload or segment, ended by the user's last flag.
// - payloads leave in exactly the order the user delivers them.
// - two bodies share one common header, sent back to back after it.
// - destination is the requested 64-bit peer identifier, never broadcast.
// - source field carries this entity's own 64-bit identifier.
// - body count byte is 1 for one body and 2 for two.
// - a 32-bit check over the 18 header bytes follows the header.
// - sync bit 7 is one only in the first data body after reset or after a resync request.
// - acknowledge type bit 6 of the attribute is always zero.
// - body type bit 5 of the attribute is always zero.
// - reserved bit 4 of the attribute is always zero.
// - check starts at all ones and absorbs bytes in send order.
// - the forbidden broadcast destination is all ones.
module data_frame_header_builder
  import framer_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // frame request
  input wire logic req_valid_i,
  input wire logic [63:0] req_dest_i,
  input wire logic [1:0] req_count_i,
  output logic req_ready_o,
  output logic req_reject_o,
  // payload bytes from the user
  input wire logic pl_valid_i,
  input wire logic [7:0] pl_data_i,
  input wire logic pl_last_i,
  output logic pl_ready_o,
  // frame bytes to the link
  output logic out_valid_o,
  output logic [7:0] out_data_o,
  output logic out_first_o,
  output logic out_last_o,
  input wire logic out_ready_i
);

  typedef struct packed {
    framer_state_t state;
    logic [4:0] idx;
    logic [1:0] count;
    logic second;
    logic [63:0] dest;
    logic [63:0] src;
    logic [31:0] chk;
    logic out_valid;
    logic [7:0] out_data;
    logic out_first;
    logic out_last;
    logic enable;
    logic sync_pending;
    logic [63:0] own_id;
    logic [15:0] frame_cnt;
    logic [15:0] reject_cnt;
    logic req_reject;
    logic [31:0] rdata;
  } framer_regs_t;

  framer_regs_t s;
  framer_regs_t next_s;

  logic [7:0] hdr_byte;
  logic [31:0] chk_next;
  logic load;
  logic req_ready;
  logic pl_ready;
  logic last_body;
  logic [7:0] attr_byte;
  logic [31:0] status_word;

  // header byte for the current position
  header_byte_mux u_hdr_mux (
    .idx_i(s.idx),
    .dest_i(s.dest),
    .src_i(s.src),
    .count_i(s.count),
    .byte_o(hdr_byte)
  );

  // check value after absorbing the header byte being sent
  header_check_step u_chk_step (
    .chk_i(s.chk),
    .data_i(hdr_byte),
    .chk_o(chk_next)
  );

  // output slot is free when empty or being drained this cycle
  assign load = !s.out_valid || out_ready_i;
  assign req_ready = s.enable && (s.state == ST_IDLE);
  assign last_body = s.second || (s.count == BODY_CNT_ONE);

  always_comb begin
    attr_byte = ATTR_BASE;
    attr_byte[ATTR_SYNC_BIT] = s.sync_pending;
    attr_byte[ATTR_ACK_BIT] = 1'b0;
    attr_byte[ATTR_TYPE_BIT] = 1'b0;
    attr_byte[ATTR_RSV_BIT] = 1'b0;
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STAT_BUSY_BIT] = (s.state != ST_IDLE);
    status_word[STAT_SYNC_BIT] = s.sync_pending;
    status_word[STAT_EN_BIT] = s.enable;
  end

  always_comb begin
    next_s = s;
    next_s.req_reject = 1'b0;
    pl_ready = 1'b0;
    if (out_ready_i) begin
      next_s.out_valid = 1'b0;
    end

    unique case (s.state)
      ST_IDLE: begin
        if (req_valid_i && req_ready) begin
          if (req_dest_i == BROADCAST_ID) begin
            next_s.req_reject = 1'b1;
            next_s.reject_cnt = s.reject_cnt + 16'h0001;
          end else if (req_count_i != BODY_CNT_ONE &&
                       req_count_i != BODY_CNT_TWO) begin
            next_s.req_reject = 1'b1;
            next_s.reject_cnt = s.reject_cnt + 16'h0001;
          end else begin
            next_s.dest = req_dest_i;
            next_s.src = s.own_id;
            next_s.count = req_count_i;
            next_s.chk = CHK_SEED;
            next_s.idx = 5'h00;
            next_s.second = 1'b0;
            next_s.state = ST_HDR;
          end
        end
      end

      ST_HDR: begin
        if (load) begin
          next_s.out_valid = 1'b1;
          next_s.out_data = hdr_byte;
          next_s.out_first = (s.idx == 5'h00);
          next_s.out_last = 1'b0;
          next_s.chk = chk_next;
          if (s.idx == HDR_LAST_POS) begin
            next_s.idx = 5'h00;
            next_s.state = ST_CHK;
          end else begin
            next_s.idx = s.idx + 5'h01;
          end
        end
      end

      ST_CHK: begin
        if (load) begin
          next_s.out_valid = 1'b1;
          next_s.out_data = s.chk[8 * (3 - s.idx[1:0]) +: 8];
          next_s.out_first = 1'b0;
          next_s.out_last = 1'b0;
          if (s.idx == CHK_LAST_POS) begin
            next_s.idx = 5'h00;
            next_s.state = ST_ATTR;
          end else begin
            next_s.idx = s.idx + 5'h01;
          end
        end
      end

      ST_ATTR: begin
        if (load) begin
          next_s.out_valid = 1'b1;
          next_s.out_data = attr_byte;
          next_s.out_first = 1'b0;
          next_s.out_last = 1'b0;
          next_s.sync_pending = 1'b0;
          next_s.state = ST_BODY;
        end
      end

      ST_BODY: begin
        pl_ready = load;
        if (pl_valid_i && load) begin
          next_s.out_valid = 1'b1;
          next_s.out_data = pl_data_i;
          next_s.out_first = 1'b0;
          next_s.out_last = 1'b0;
          if (pl_last_i) begin
            if (last_body) begin
              next_s.out_last = 1'b1;
              next_s.frame_cnt = s.frame_cnt + 16'h0001;
              next_s.state = ST_IDLE;
            end else begin
              next_s.second = 1'b1;
              next_s.state = ST_ATTR;
            end
          end
        end
      end

      default: begin
        next_s.state = ST_IDLE;
      end
    endcase

    // register writes; a resync request wins over the clear above
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        REG_OWN_ID_LO: begin
          next_s.own_id[31:0] = reg_wdata_i;
        end
        REG_OWN_ID_HI: begin
          next_s.own_id[63:32] = reg_wdata_i;
        end
        REG_CTRL: begin
          next_s.enable = reg_wdata_i[CTRL_EN_BIT];
          if (reg_wdata_i[CTRL_RESYNC_BIT]) begin
            next_s.sync_pending = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // read data stand one cycle after the strobe only
    next_s.rdata = 32'h0000_0000;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        REG_OWN_ID_LO: begin
          next_s.rdata = s.own_id[31:0];
        end
        REG_OWN_ID_HI: begin
          next_s.rdata = s.own_id[63:32];
        end
        REG_CTRL: begin
          next_s.rdata[CTRL_EN_BIT] = s.enable;
        end
        REG_STATUS: begin
          next_s.rdata = status_word;
        end
        REG_FRAME_CNT: begin
          next_s.rdata = {16'h0000, s.frame_cnt};
        end
        REG_REJECT_CNT: begin
          next_s.rdata = {16'h0000, s.reject_cnt};
        end
        default: begin
          next_s.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s.state <= ST_IDLE;
      s.idx <= 5'h00;
      s.count <= BODY_CNT_ONE;
      s.second <= 1'b0;
      s.dest <= 64'h0000_0000_0000_0000;
      s.src <= 64'h0000_0000_0000_0000;
      s.chk <= CHK_SEED;
      s.out_valid <= 1'b0;
      s.out_data <= 8'h00;
      s.out_first <= 1'b0;
      s.out_last <= 1'b0;
      s.enable <= CTRL_EN_RESET;
      s.sync_pending <= SYNC_PENDING_RESET;
      s.own_id <= OWN_ID_RESET;
      s.frame_cnt <= 16'h0000;
      s.reject_cnt <= 16'h0000;
      s.req_reject <= 1'b0;
      s.rdata <= 32'h0000_0000;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata_o = s.rdata;
  assign req_ready_o = req_ready;
  assign req_reject_o = s.req_reject;
  assign pl_ready_o = pl_ready;
  assign out_valid_o = s.out_valid;
  assign out_data_o = s.out_data;
  assign out_first_o = s.out_first;
  assign out_last_o = s.out_last;

endmodule
`default_nettype wire

// ==== rtl/framer_pkg.sv ====
// shared constants and types of the data frame header builder
package framer_pkg;

  // field widths
  localparam int ID_W = 64;
  localparam int CHK_W = 32;
  localparam int IDX_W = 5;

  // header layout, byte positions in send order
  localparam logic [4:0] HDR_SRC_POS = 5'h08;
  localparam logic [4:0] HDR_RSV_POS = 5'h10;
  localparam logic [4:0] HDR_MUX_POS = 5'h11;
  localparam logic [4:0] HDR_LAST_POS = 5'h11;
  localparam logic [4:0] CHK_LAST_POS = 5'h03;
  localparam logic [7:0] HDR_RSV_BYTE = 8'h00;

  // body count values
  localparam logic [1:0] BODY_CNT_ONE = 2'h1;
  localparam logic [1:0] BODY_CNT_TWO = 2'h2;

  // identifier that no data frame may address
  localparam logic [63:0] BROADCAST_ID = 64'hFFFF_FFFF_FFFF_FFFF;

  // header check
  localparam logic [31:0] CHK_SEED = 32'hFFFF_FFFF;
  localparam logic [31:0] CHK_POLY = 32'h04C1_1DB7;

  // sub-header attribute byte
  localparam int ATTR_SYNC_BIT = 7;
  localparam int ATTR_ACK_BIT = 6;
  localparam int ATTR_TYPE_BIT = 5;
  localparam int ATTR_RSV_BIT = 4;
  localparam logic [7:0] ATTR_BASE = 8'h00;

  // register offsets
  localparam logic [7:0] REG_OWN_ID_LO = 8'h00;
  localparam logic [7:0] REG_OWN_ID_HI = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_FRAME_CNT = 8'h10;
  localparam logic [7:0] REG_REJECT_CNT = 8'h14;

  // control and status fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_RESYNC_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SYNC_BIT = 1;
  localparam int STAT_EN_BIT = 2;

  // reset values
  localparam logic CTRL_EN_RESET = 1'b0;
  localparam logic SYNC_PENDING_RESET = 1'b1;
  localparam logic [63:0] OWN_ID_RESET = 64'h0000_0000_0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HDR,
    ST_CHK,
    ST_ATTR,
    ST_BODY
  } framer_state_t;

endpackage

// ==== rtl/header_check_step.sv ====
// one byte step of the 32-bit header check
`timescale 1ns/10ps
`default_nettype none
module header_check_step
  import framer_pkg::*;
(
  // running check and next byte
  input wire logic [31:0] chk_i,
  input wire logic [7:0] data_i,
  // updated check
  output logic [31:0] chk_o
);

  always_comb begin
    logic [31:0] q;
    logic fb;
    q = chk_i;
    fb = 1'b0;
    // shift in one bit at a time, bit 0 of the byte first
    for (int i = 0; i < 8; i++) begin
      fb = q[31] ^ data_i[i];
      q = {q[30:0], 1'b0} ^ (fb ? CHK_POLY : 32'h0000_0000);
    end
    chk_o = q;
  end

endmodule
`default_nettype wire

// ==== rtl/header_byte_mux.sv ====
// selects the common header byte for a byte position
`timescale 1ns/10ps
`default_nettype none
module header_byte_mux
  import framer_pkg::*;
(
  // header contents
  input wire logic [4:0] idx_i,
  input wire logic [63:0] dest_i,
  input wire logic [63:0] src_i,
  input wire logic [1:0] count_i,
  // selected byte
  output logic [7:0] byte_o
);

  always_comb begin
    byte_o = HDR_RSV_BYTE;
    // identifiers go most significant byte first
    if (idx_i < HDR_SRC_POS) begin
      byte_o = dest_i[8 * (7 - idx_i[2:0]) +: 8];
    end else if (idx_i < HDR_RSV_POS) begin
      byte_o = src_i[8 * (7 - idx_i[2:0]) +: 8];
    end else if (idx_i == HDR_MUX_POS) begin
      byte_o = {6'h00, count_i};
    end
  end

endmodule
`default_nettype wire

// ==== test/data_frame_header_builder_chk.sv ====
// port checker for the data frame header builder
`timescale 1ns/10ps
`default_nettype none
module data_frame_header_builder_chk
  import framer_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // request and stream
  input wire logic req_valid_i,
  input wire logic [63:0] req_dest_i,
  input wire logic [1:0] req_count_i,
  input wire logic req_ready_o,
  input wire logic req_reject_o,
  input wire logic out_valid_o,
  input wire logic [7:0] out_data_o,
  input wire logic out_first_o,
  input wire logic out_ready_i
);
  logic [15:0] idx;
  logic [1:0] cnt;
  logic [7:0] dest_msb;
  logic take;
  logic good;
  assign take = req_valid_i && req_ready_o;
  assign good = (req_dest_i != BROADCAST_ID) &&
    (req_count_i == BODY_CNT_ONE || req_count_i == BODY_CNT_TWO);
  // byte index of the byte now on the output
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      idx <= 16'h0000;
      cnt <= 2'h0;
      dest_msb <= 8'h00;
    end else if (take) begin
      idx <= 16'h0000;
      cnt <= req_count_i;
      dest_msb <= req_dest_i[63:56];
    end else if (out_valid_o && out_ready_i) begin
      idx <= idx + 16'h0001;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  property p_bcast;
    take && req_dest_i == BROADCAST_ID |=> req_reject_o;
  endproperty
  a_bcast: assert property (p_bcast)
    else $error("broadcast destination not refused");
  property p_badcnt;
    take && (req_count_i == 2'h0 || req_count_i == 2'h3)
      |=> req_reject_o && !out_valid_o;
  endproperty
  a_badcnt: assert property (p_badcnt)
    else $error("bad body count not refused");
  property p_refuse;
    req_reject_o |-> !out_valid_o && $past(take);
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("refusal without a request");
  property p_start;
    take && good |-> ##2 out_valid_o && out_first_o &&
      out_data_o == dest_msb;
  endproperty
  a_start: assert property (p_start)
    else $error("frame does not start with destination");
  property p_first;
    out_valid_o && out_first_o |-> idx == 16'h0000 && !req_ready_o;
  endproperty
  a_first: assert property (p_first)
    else $error("first flag off the header start");
  property p_hold;
    out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("byte lost during stall");
  property p_count;
    out_valid_o && idx == 16'h0011 |-> out_data_o == {6'h00, cnt};
  endproperty
  a_count: assert property (p_count)
    else $error("body count byte wrong");
  property p_attr;
    out_valid_o && idx == 16'h0016 |-> out_data_o[6:4] == 3'h0;
  endproperty
  a_attr: assert property (p_attr)
    else $error("attribute bits 6 to 4 not zero");
endmodule
bind data_frame_header_builder data_frame_header_builder_chk
  data_frame_header_builder_chk_inst (.ref_clk_i, .rst_i, .req_valid_i,
  .req_dest_i, .req_count_i, .req_ready_o, .req_reject_o, .out_valid_o,
  .out_data_o, .out_first_o, .out_ready_i);
`default_nettype wire

// ==== test/link_sink.sv ====
// peer link entity model: takes frame bytes, may stall, checks header
`timescale 1ns/10ps
`default_nettype none
module link_sink
  import framer_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // stall control
  input wire logic stall_i,
  // frame stream
  input wire logic out_valid_i,
  input wire logic [7:0] out_data_i,
  input wire logic out_last_i,
  output logic out_ready_o
);
  logic [7:0] q[$];
  int frames = 0;
  int bad = 0;
  logic [1:0] cnt;
  // seed all ones, bytes in send order
  function automatic logic [31:0] hdr_chk(input logic [7:0] b[$]);
    logic [31:0] c;
    logic fb;
    c = CHK_SEED;
    for (int n = 0; n < 18; n++) begin
      for (int i = 0; i < 8; i++) begin
        fb = c[31] ^ b[n][i];
        c = {c[30:0], 1'b0} ^ (fb ? CHK_POLY : 32'h0000_0000);
      end
    end
    return c;
  endfunction
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_ready_o <= 1'b0;
      cnt <= 2'h0;
    end else begin
      cnt <= cnt + 2'h1;
      out_ready_o <= !stall_i || (cnt == 2'h0);
      if (out_valid_i && out_ready_o) begin
        q.push_back(out_data_i);
        if (out_last_i) begin
          frames <= frames + 1;
          // count frames whose header check disagrees
          if (hdr_chk(q) !== {q[18], q[19], q[20], q[21]}) bad <= bad + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== test/data_frame_header_builder_test.sv ====
// self-checking bench of the data frame header builder
`timescale 1ns/10ps
`default_nettype none
module data_frame_header_builder_test;
  import framer_pkg::*;
  logic ref_clk_i, rst_i, reg_wr_i, reg_rd_i, req_valid_i, pl_valid_i;
  logic pl_last_i, req_ready_o, req_reject_o, pl_ready_o, out_valid_o;
  logic out_first_o, out_last_o, out_ready_i, stall, sync_exp;
  logic [7:0] reg_addr_i, pl_data_i, out_data_o;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic [63:0] req_dest_i, own_id;
  logic [1:0] req_count_i;
  logic [7:0] exp_q[$];
  int mismatches = 0;
  int check_count = 0;
  int seed = 96;
  data_frame_header_builder data_frame_header_builder_inst (.ref_clk_i,
    .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .req_valid_i, .req_dest_i, .req_count_i, .req_ready_o, .req_reject_o,
    .pl_valid_i, .pl_data_i, .pl_last_i, .pl_ready_o, .out_valid_o,
    .out_data_o, .out_first_o, .out_last_o, .out_ready_i);
  link_sink link_sink_inst (.ref_clk_i, .rst_i, .stall_i(stall),
    .out_valid_i(out_valid_o), .out_data_i(out_data_o),
    .out_last_i(out_last_o), .out_ready_o(out_ready_i));
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string w, input logic [63:0] e, logic [63:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wait_neg(ref logic s, input string w);
    int n;
    n = 0;
    @(negedge ref_clk_i);
    while (s !== 1'b1) begin
      n++;
      if (n > 500) begin
        chk(w, 1, 0);
        final_report();
      end
      @(negedge ref_clk_i);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, logic [31:0] e, string w);
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge ref_clk_i);
    chk(w, e, reg_rdata_o);
  endtask
  task automatic request(input logic [63:0] d, input logic [1:0] c);
    @(posedge ref_clk_i);
    req_valid_i <= 1'b1;
    req_dest_i <= d;
    req_count_i <= c;
    wait_neg(req_ready_o, "request ready");
    @(posedge ref_clk_i);
    req_valid_i <= 1'b0;
  endtask
  task automatic refuse(input logic [63:0] d, input logic [1:0] c);
    request(d, c);
    @(negedge ref_clk_i);
    chk("reject pulse", 1, req_reject_o);
  endtask
  task automatic frame(input logic [1:0] cnt, input int len);
    logic [7:0] b;
    logic [63:0] dest;
    logic [31:0] crc;
    int n0;
    dest = {$random(seed), $random(seed)};
    // keep the random peer off the refused broadcast value
    if (dest == BROADCAST_ID) dest[0] = 1'b0;
    exp_q.delete();
    for (int i = 7; i >= 0; i--) exp_q.push_back(dest[i*8 +: 8]);
    for (int i = 7; i >= 0; i--) exp_q.push_back(own_id[i*8 +: 8]);
    exp_q.push_back(HDR_RSV_BYTE);
    exp_q.push_back({6'h00, cnt});
    crc = link_sink_inst.hdr_chk(exp_q);
    for (int i = 3; i >= 0; i--) exp_q.push_back(crc[i*8 +: 8]);
    link_sink_inst.q.delete();
    n0 = link_sink_inst.frames;
    request(dest, cnt);
    for (int k = 0; k < cnt; k++) begin
      exp_q.push_back({sync_exp, 7'h00});
      sync_exp = 1'b0;
      for (int i = 0; i < len + k; i++) begin
        b = 8'($random(seed));
        exp_q.push_back(b);
        pl_valid_i <= 1'b1;
        pl_data_i <= b;
        pl_last_i <= (i == len + k - 1);
        wait_neg(pl_ready_o, "payload ready");
        @(posedge ref_clk_i);
      end
    end
    pl_valid_i <= 1'b0;
    repeat (400) if (link_sink_inst.frames == n0) @(negedge ref_clk_i);
    chk("frame done", n0 + 1, link_sink_inst.frames);
    if (link_sink_inst.frames == n0) final_report();
    chk("frame length", exp_q.size(), link_sink_inst.q.size());
    foreach (exp_q[i]) chk("frame byte", exp_q[i], link_sink_inst.q[i]);
    $display("frame with %0d bodies done", cnt);
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    {reg_wr_i, reg_rd_i, req_valid_i, pl_valid_i, pl_last_i, stall} = 6'h00;
    {reg_addr_i, pl_data_i, reg_wdata_i, req_count_i} = 50'h0;
    req_dest_i = 64'h0;
    sync_exp = 1'b1;
    rst_i = 1'b1;
    repeat (8) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    reg_rd(REG_STATUS, 32'h0000_0002, "status at reset");
    reg_rd(REG_CTRL, 32'h0000_0000, "control at reset");
    own_id = {$random(seed), $random(seed)};
    reg_wr(REG_OWN_ID_LO, own_id[31:0]);
    reg_wr(REG_OWN_ID_HI, own_id[63:32]);
    reg_rd(REG_OWN_ID_HI, own_id[63:32], "own id high");
    reg_rd(8'h40, 32'h0000_0000, "unmapped read");
    reg_wr(REG_CTRL, 32'h0000_0001);
    reg_rd(REG_STATUS, 32'h0000_0006, "status enabled");
    $display("register test done");
    refuse(BROADCAST_ID, BODY_CNT_ONE);
    refuse(64'h0000_0000_0000_1234, 2'h0);
    refuse(64'h0000_0000_0000_1234, 2'h3);
    reg_rd(REG_REJECT_CNT, 32'h0000_0003, "reject count");
    $display("refusal test done");
    for (int f = 0; f < 8; f++) begin
      stall <= f[0];
      frame(f[1] ? BODY_CNT_TWO : BODY_CNT_ONE, 1 + ($random(seed) & 3));
      if (f == 4) begin
        reg_wr(REG_CTRL, 32'h0000_0003);
        reg_rd(REG_CTRL, 32'h0000_0001, "resync reads zero");
        reg_rd(REG_STATUS, 32'h0000_0006, "status resync");
        sync_exp = 1'b1;
      end
    end
    reg_rd(REG_FRAME_CNT, 32'h0000_0008, "frame count");
    reg_rd(REG_STATUS, 32'h0000_0004, "status after frames");
    chk("peer header check errors", 0, link_sink_inst.bad);
    final_report();
  end
endmodule
`default_nettype wire
